// file: common/blgc_regs.vh
`ifndef BLGC_REGS_VH
`define BLGC_REGS_VH

// ---------------------------------------------------------------------------
// Register offsets.
// ---------------------------------------------------------------------------
`define BLGC_MODE_CONTROL_ADDR      8'h01
`define BLGC_CONFIGURATION_ADDR     8'h04
`define BLGC_DAYLIGHT_MAX_ADDR      8'h09
`define BLGC_DAYLIGHT_DIM_ADDR      8'h0a
`define BLGC_OFFICE_MAX_ADDR        8'h0b
`define BLGC_OFFICE_DIM_ADDR        8'h0c
`define BLGC_DARK_MAX_ADDR          8'h0d
`define BLGC_DARK_DIM_ADDR          8'h0e
`define BLGC_STATUS_ADDR            8'h10
`define BLGC_STATE_ADDR             8'h11

// ---------------------------------------------------------------------------
// Field positions.
// ---------------------------------------------------------------------------
`define BLGC_ACTIVE_ENABLE_BIT      5
`define BLGC_AMBIENT_AUTO_EN_BIT    4
`define BLGC_DIM_EN_BIT             1
`define BLGC_BACKLIGHT_ON_BIT       0
`define BLGC_LEVEL_LSB              0
`define BLGC_LEVEL_MSB              1
`define BLGC_SINK_MASK_LSB          0

// ---------------------------------------------------------------------------
// Level codes and gain codes.
// ---------------------------------------------------------------------------
`define BLGC_LEVEL_DAYLIGHT         2'h0
`define BLGC_LEVEL_OFFICE           2'h1
`define BLGC_LEVEL_DARK             2'h2
`define BLGC_GAIN_1X                2'h0
`define BLGC_GAIN_1P5X              2'h1
`define BLGC_GAIN_2X                2'h2
`define BLGC_GAIN_OFF               2'h3

// ---------------------------------------------------------------------------
// Reset values.
// ---------------------------------------------------------------------------
`define BLGC_MODE_RESET             8'h00
`define BLGC_CONFIG_RESET           8'h00
`define BLGC_LEVEL_RESET            8'h00
`define BLGC_SINK_EN_RESET          8'h7f

// ---------------------------------------------------------------------------
// Timing: times in ns, counts derived at 5 ns per cycle.
// ---------------------------------------------------------------------------
`define BLGC_CLK_PERIOD_NS          5
`define BLGC_SETTLE_NS              100000
`define BLGC_SETTLE_CYC             (`BLGC_SETTLE_NS / `BLGC_CLK_PERIOD_NS)
`define BLGC_RST_FILTER_NS          50000
`define BLGC_RST_FILTER_CYC         (`BLGC_RST_FILTER_NS / `BLGC_CLK_PERIOD_NS)

`endif

// file: verilog/blgc_top.v
// Summary of operation
// (R1) Start every run at unity pump gain.
// (R2) Any enabled sink low: raise gain one step.
// (R3) Wait settle interval after each gain change.
// (R4) Still low after settling: raise to 2x.
// (R5) All enabled sinks high: lower one step.
// (R6) Ignore headroom flags of disabled sinks.
// (R7) Soft start until output near input, then 1x.
// (R8) Soft start on UVLO, fault, standby exit.
// (R9) Faults open all pump switches.
// (R10) Active enable bit set selects active mode.
// (R11) Standby when enable clear or reset pin held.
// (R12) Undervoltage resets registers, then standby.
// (R13) Power-on reset defaults registers, enters standby.
// (R14) Reset pin low: standby, defaults, no acknowledge.
// (R15) After release: defaults, standby, commands accepted.
// (R16) Reset pin acts only after full filter time.
// (R17) Level field: 00 daylight, 01 office, 10 dark.
// (R18) Level written by host or ambient logic.
// (R19) Each level uses its own max/dim pair.
// (R20) Backlight on follows backlight-on bit when active; the code holds it off during soft start and fault.
// (R21) Analog flags synchronized before use.
`timescale 1ns/10ps
`default_nettype none
`include "blgc_regs.vh"

module blgc_top #(
  // Sink count, then timing counts in core clock cycles.
  parameter                    NUM_SINKS  = 7,
  parameter                    SETTLE_CYC = `BLGC_SETTLE_CYC,
  parameter                    FILTER_CYC = `BLGC_RST_FILTER_CYC
) (
  input  wire                  CORE_CLK,
  input  wire                  RST_B,
  // Pin and analog levels, synchronised inside; the ambient level inputs are used unsynchronised.
  input  wire                  HW_RESET_PIN_N,
  input  wire                  UVLO_N,
  input  wire                  FAULT,
  input  wire                  SOFT_START_DONE,
  input  wire [NUM_SINKS-1:0]  HEADROOM_LOW,
  input  wire [NUM_SINKS-1:0]  HEADROOM_HIGH,
  input  wire                  AMBIENT_LEVEL_VALID,
  input  wire [1:0]            AMBIENT_LEVEL,
  // Register strobe bus on the core clock.
  input  wire                  REG_WR,
  input  wire                  REG_RD,
  input  wire [7:0]            REG_ADDR,
  input  wire [7:0]            REG_WDATA,
  output reg  [7:0]            REG_RDATA,
  output reg                   REG_ACK,
  // Pump, mode and brightness outputs.
  output reg  [1:0]            PUMP_GAIN,
  output reg                   SOFT_START_EN,
  output reg                   ACTIVE,
  output reg                   BACKLIGHT_ON,
  output reg                   DIM_SEL,
  output reg  [7:0]            MAX_LEVEL,
  output reg  [7:0]            DIM_LEVEL,
  output reg  [NUM_SINKS-1:0]  SINK_EN
);

  // -------------------------------------------------------------------------
  // State encodings.
  // -------------------------------------------------------------------------
  localparam [4:0] ST_STANDBY = 5'h01;  // Pump off, waiting for enable.
  localparam [4:0] ST_SOFT    = 5'h02;  // Limited current charge.
  localparam [4:0] ST_RUN     = 5'h04;  // Gain decisions allowed.
  localparam [4:0] ST_SETTLE  = 5'h08;  // Waiting after a gain change.
  localparam [4:0] ST_FAULT   = 5'h10;  // Switches open.
  // Any other code is caught by the default branch.

  // -------------------------------------------------------------------------
  // Synchronisers for asynchronous inputs.
  // -------------------------------------------------------------------------
  reg [NUM_SINKS+3:0] sync1_reg;      // First stage, read only by second.
  reg [NUM_SINKS+3:0] sync2_reg;      // Second stage, used by logic.
  reg [NUM_SINKS-1:0] hr_high_s1_reg; // First stage of high flags.
  reg [NUM_SINKS-1:0] hr_high_reg;    // Synchronised high flags.
  wire                rst_pin_s;      // Synchronised reset pin.
  wire                uvlo_n_s;       // Synchronised supply good.
  wire                fault_s;        // Synchronised fault.
  wire                ss_done_s;      // Synchronised soft start done.
  wire [NUM_SINKS-1:0] hr_low_s;      // Synchronised low flags.

  // Two flops on every analog or pin input except the ambient level inputs.
  always @(posedge CORE_CLK) begin
    if (!RST_B) begin
      // Pin and supply bits reset to their idle high level, so that
      // no false pin reset or undervoltage follows the core reset.
      sync1_reg      <= {{(NUM_SINKS+2){1'b0}}, 2'h3};
      sync2_reg      <= {{(NUM_SINKS+2){1'b0}}, 2'h3};
      hr_high_s1_reg <= {NUM_SINKS{1'b0}};
      hr_high_reg    <= {NUM_SINKS{1'b0}};
    end else begin
      // Low flags and pin levels share one chain.
      sync1_reg      <= {HEADROOM_LOW, SOFT_START_DONE, FAULT, UVLO_N, HW_RESET_PIN_N}; // [R21]
      sync2_reg      <= sync1_reg;                                                   // [R21]
      hr_high_s1_reg <= HEADROOM_HIGH;                                               // [R21]
      hr_high_reg    <= hr_high_s1_reg;                                              // [R21]
    end
  end

  // Only the second stage is read by logic.
  assign rst_pin_s = sync2_reg[0];
  assign uvlo_n_s  = sync2_reg[1];
  assign fault_s   = sync2_reg[2];
  assign ss_done_s = sync2_reg[3];
  assign hr_low_s  = sync2_reg[NUM_SINKS+3:4];

  // -------------------------------------------------------------------------
  // Reset pin noise filter.
  // -------------------------------------------------------------------------
  reg [31:0] filt_cnt_reg;    // Cycles the pin has been low.
  reg        pin_reset_reg;   // Filtered reset pin is active.
  // The count stops at the limit, so a long hold keeps reset on.

  // Only a low lasting the whole filter time asserts reset.
  always @(posedge CORE_CLK) begin
    if (!RST_B) begin
      filt_cnt_reg  <= 32'h0;
      pin_reset_reg <= 1'b0;
    end else if (rst_pin_s) begin
      // Pin high: restart the count and release reset.
      filt_cnt_reg  <= 32'h0;
      pin_reset_reg <= 1'b0;                            // [R15]
    end else if (filt_cnt_reg >= FILTER_CYC - 1) begin
      // Low for the whole filter time: reset takes hold.
      pin_reset_reg <= 1'b1;                            // [R16]
    end else begin
      // A shorter glitch never reaches the limit.
      filt_cnt_reg  <= filt_cnt_reg + 32'h1;            // [R16]
    end
  end

  // Registers go to defaults under core reset, undervoltage or reset pin.
  wire reg_clear = !uvlo_n_s || pin_reset_reg;          // [R12] [R13] [R14]

  // -------------------------------------------------------------------------
  // Register file.
  // -------------------------------------------------------------------------
  reg [7:0] mode_reg;           // Mode control register.
  reg [7:0] config_reg;         // Configuration register, level field.
  reg [7:0] level_reg [0:5];    // Max/dim pairs for three levels.
  reg [7:0] sink_en_reg;        // Sink enable mask.
  wire      bus_ok = !reg_clear;
  wire      ambient_auto = mode_reg[`BLGC_AMBIENT_AUTO_EN_BIT];
  integer   i;

  // Host writes; ambient logic owns the level field in auto mode.
  always @(posedge CORE_CLK) begin
    if (!RST_B || reg_clear) begin
      mode_reg    <= `BLGC_MODE_RESET;                  // [R13] [R14]
      config_reg  <= `BLGC_CONFIG_RESET;                // [R17]
      sink_en_reg <= `BLGC_SINK_EN_RESET;
      // Every max and dim level returns to zero.
      for (i = 0; i < 6; i = i + 1) begin
        level_reg[i] <= `BLGC_LEVEL_RESET;
      end
    end else begin
      // Writes land on the strobe edge; unknown offsets are ignored.
      if (REG_WR) begin
        case (REG_ADDR)
          `BLGC_MODE_CONTROL_ADDR: begin
            mode_reg <= REG_WDATA;                      // [R10]
          end
          `BLGC_CONFIGURATION_ADDR: begin
            if (ambient_auto) begin
              // Level bits stay with the ambient logic.
              config_reg <= {REG_WDATA[7:2], config_reg[1:0]};
            end else begin
              config_reg <= REG_WDATA;                  // [R18]
            end
          end
          `BLGC_DAYLIGHT_MAX_ADDR: level_reg[0] <= REG_WDATA;
          `BLGC_DAYLIGHT_DIM_ADDR: level_reg[1] <= REG_WDATA;
          `BLGC_OFFICE_MAX_ADDR:   level_reg[2] <= REG_WDATA;
          `BLGC_OFFICE_DIM_ADDR:   level_reg[3] <= REG_WDATA;
          `BLGC_DARK_MAX_ADDR:     level_reg[4] <= REG_WDATA;
          `BLGC_DARK_DIM_ADDR:     level_reg[5] <= REG_WDATA;
          `BLGC_STATUS_ADDR:       sink_en_reg  <= REG_WDATA;
          default: begin
          end
        endcase
      end
      // The ambient update comes last and wins over a host write.
      // Code 11 is not a level and is dropped.
      if (ambient_auto && AMBIENT_LEVEL_VALID && AMBIENT_LEVEL != 2'h3) begin
        config_reg[`BLGC_LEVEL_MSB:`BLGC_LEVEL_LSB] <= AMBIENT_LEVEL;  // [R18]
      end
    end
  end

  // -------------------------------------------------------------------------
  // Gain and mode sequencer.
  // -------------------------------------------------------------------------
  reg [4:0]  state_reg;          // One-hot sequencer state.
  reg [4:0]  state_next;
  reg [1:0]  gain_reg;           // Present pump gain.
  reg [1:0]  gain_next;
  reg [31:0] settle_cnt_reg;     // Settling countdown.
  reg [31:0] settle_cnt_next;

  // Disabled sinks never drive a gain decision.
  wire [NUM_SINKS-1:0] en_mask = sink_en_reg[NUM_SINKS-1:0];
  wire any_low  = |(hr_low_s & en_mask);                       // [R6]
  wire all_high = &(hr_high_reg | ~en_mask);                   // [R6]
  wire go_active = mode_reg[`BLGC_ACTIVE_ENABLE_BIT] && !reg_clear && uvlo_n_s; // [R10] [R11]

  // Next-state logic for soft start and automatic gain.
  always @* begin
    state_next      = state_reg;
    gain_next       = gain_reg;
    settle_cnt_next = settle_cnt_reg;
    case (state_reg)
      ST_STANDBY: begin
        // Switches open until the enable bit is set.
        gain_next = `BLGC_GAIN_OFF;
        if (go_active) begin
          state_next = ST_SOFT;                                 // [R8]
        end
      end
      ST_SOFT: begin
        // Limited current charge, then unity gain.
        gain_next = `BLGC_GAIN_OFF;
        if (ss_done_s) begin
          state_next = ST_RUN;                                  // [R7]
          gain_next  = `BLGC_GAIN_1X;                           // [R1]
        end
      end
      ST_RUN: begin
        // Up on any low flag, down only when all are high.
        if (any_low && gain_reg != `BLGC_GAIN_2X) begin
          gain_next       = gain_reg + 2'h1;                    // [R2] [R4]
          state_next      = ST_SETTLE;
          settle_cnt_next = SETTLE_CYC - 1;                     // [R3]
        end else if (!any_low && all_high && gain_reg != `BLGC_GAIN_1X) begin
          gain_next       = gain_reg - 2'h1;                    // [R5]
          state_next      = ST_SETTLE;
          settle_cnt_next = SETTLE_CYC - 1;                     // [R3]
        end
      end
      ST_SETTLE: begin
        // Hold the gain while the output settles.
        if (settle_cnt_reg == 32'h0) begin
          state_next = ST_RUN;                                  // [R3]
        end else begin
          settle_cnt_next = settle_cnt_reg - 32'h1;
        end
      end
      ST_FAULT: begin
        // Stay isolated until the fault clears.
        gain_next = `BLGC_GAIN_OFF;                             // [R9]
        if (!fault_s) begin
          state_next = ST_SOFT;                                 // [R8]
        end
      end
      default: begin
        // An illegal code falls back to standby.
        state_next = ST_STANDBY;
        gain_next  = `BLGC_GAIN_OFF;
      end
    endcase
    // Leaving active mode or a fault overrides every state.
    if (!go_active) begin
      state_next = ST_STANDBY;                                  // [R11]
      gain_next  = `BLGC_GAIN_OFF;
    end else if (fault_s) begin
      state_next = ST_FAULT;                                    // [R9]
      gain_next  = `BLGC_GAIN_OFF;
    end
  end

  // State registers.
  always @(posedge CORE_CLK) begin
    if (!RST_B) begin
      // Core reset parks the sequencer with the pump open.
      state_reg      <= ST_STANDBY;                             // [R13]
      gain_reg       <= `BLGC_GAIN_OFF;
      settle_cnt_reg <= 32'h0;
    end else begin
      state_reg      <= state_next;
      gain_reg       <= gain_next;
      settle_cnt_reg <= settle_cnt_next;
    end
  end

  // -------------------------------------------------------------------------
  // Outputs and register read port.
  // -------------------------------------------------------------------------
  // Level 11 is undefined and falls back to the daylight pair.
  wire [1:0] level_sel = config_reg[`BLGC_LEVEL_MSB:`BLGC_LEVEL_LSB];
  wire [2:0] pair_idx  = (level_sel == `BLGC_LEVEL_OFFICE) ? 3'h2 :
                         (level_sel == `BLGC_LEVEL_DARK)   ? 3'h4 : 3'h0;  // [R17] [R19]
  wire       run_now   = (state_reg == ST_RUN) || (state_reg == ST_SETTLE);
  wire [7:0] status    = {3'h0, state_reg};

  // Every output is registered.
  always @(posedge CORE_CLK) begin
    if (!RST_B) begin
      REG_RDATA     <= 8'h00;
      REG_ACK       <= 1'b0;
      PUMP_GAIN     <= `BLGC_GAIN_OFF;
      SOFT_START_EN <= 1'b0;
      ACTIVE        <= 1'b0;
      BACKLIGHT_ON  <= 1'b0;
      DIM_SEL       <= 1'b0;
      MAX_LEVEL     <= 8'h00;
      DIM_LEVEL     <= 8'h00;
      SINK_EN       <= {NUM_SINKS{1'b0}};
    end else begin
      // The acknowledge is withheld while held in reset.
      REG_ACK       <= (REG_WR || REG_RD) && bus_ok;            // [R14] [R15]
      // Read data follows the address every cycle.
      case (REG_ADDR)
        `BLGC_MODE_CONTROL_ADDR:  REG_RDATA <= mode_reg;
        `BLGC_CONFIGURATION_ADDR: REG_RDATA <= config_reg;
        `BLGC_DAYLIGHT_MAX_ADDR:  REG_RDATA <= level_reg[0];
        `BLGC_DAYLIGHT_DIM_ADDR:  REG_RDATA <= level_reg[1];
        `BLGC_OFFICE_MAX_ADDR:    REG_RDATA <= level_reg[2];
        `BLGC_OFFICE_DIM_ADDR:    REG_RDATA <= level_reg[3];
        `BLGC_DARK_MAX_ADDR:      REG_RDATA <= level_reg[4];
        `BLGC_DARK_DIM_ADDR:      REG_RDATA <= level_reg[5];
        `BLGC_STATUS_ADDR:        REG_RDATA <= sink_en_reg;
        `BLGC_STATE_ADDR:         REG_RDATA <= {gain_reg, 1'b0, status[4:0]};
        default:                  REG_RDATA <= 8'h00;
      endcase
      // Pump control shows the next state, one flop deep.
      PUMP_GAIN     <= gain_next;                               // [R1] [R9]
      SOFT_START_EN <= (state_next == ST_SOFT);                 // [R7]
      ACTIVE        <= go_active;                               // [R10]
      BACKLIGHT_ON  <= run_now && mode_reg[`BLGC_BACKLIGHT_ON_BIT]; // [R20]
      DIM_SEL       <= mode_reg[`BLGC_DIM_EN_BIT];
      MAX_LEVEL     <= level_reg[pair_idx];                     // [R19]
      DIM_LEVEL     <= level_reg[pair_idx + 3'h1];              // [R19]
      SINK_EN       <= go_active ? en_mask : {NUM_SINKS{1'b0}}; // [R6]
    end
  end

endmodule // blgc_top

`default_nettype wire

// file: testbench/blgc_top_sva.sv
`timescale 1ns/10ps
`default_nettype none
// ---------------------------------------------------------------------------
// Port checker for the mode and gain controller.
// ---------------------------------------------------------------------------
module blgc_top_sva #(
  parameter int NUM_SINKS  = 7,
  parameter int FILTER_CYC = 10
) (
  input wire logic                 CORE_CLK,
  input wire logic                 RST_B,
  input wire logic                 HW_RESET_PIN_N,
  input wire logic                 UVLO_N,
  input wire logic                 FAULT,
  input wire logic                 REG_WR,
  input wire logic                 REG_RD,
  input wire logic                 REG_ACK,
  input wire logic [1:0]           PUMP_GAIN,
  input wire logic                 SOFT_START_EN,
  input wire logic                 ACTIVE,
  input wire logic                 BACKLIGHT_ON,
  input wire logic [NUM_SINKS-1:0] SINK_EN
);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!RST_B);
  logic [15:0] low_cnt_reg; // Counts cycles that the reset pin has been low.
  // The counter saturates so that a long hold never wraps back to zero.
  always_ff @(posedge CORE_CLK) begin
    if (!RST_B || HW_RESET_PIN_N) begin
      low_cnt_reg <= 16'h0000;
    end else if (low_cnt_reg != 16'hffff) begin
      low_cnt_reg <= low_cnt_reg + 16'h0001;
    end
  end
  ack_has_cause_a: assert property (REG_ACK |-> $past(REG_WR || REG_RD))
    else $error("acknowledge without a strobe");
  uvlo_no_ack_a: assert property (!UVLO_N [*5] |-> !REG_ACK)
    else $error("acknowledge while supply is low");
  pin_reset_a: assert property ((low_cnt_reg > FILTER_CYC + 6) |-> !REG_ACK && !ACTIVE)
    else $error("pin reset did not hold standby");
  fault_open_a: assert property (FAULT [*6] |-> PUMP_GAIN == 2'h3)
    else $error("pump switches not opened on fault");
  gain_step_a: assert property (($changed(PUMP_GAIN) && ACTIVE && $past(ACTIVE) &&
    PUMP_GAIN != 2'h3 && $past(PUMP_GAIN) != 2'h3) |->
    (PUMP_GAIN == $past(PUMP_GAIN) + 2'h1 || PUMP_GAIN == $past(PUMP_GAIN) - 2'h1))
    else $error("gain moved more than one step");
  settle_hold_a: assert property (($changed(PUMP_GAIN) && ACTIVE && PUMP_GAIN != 2'h3 &&
    $past(PUMP_GAIN) != 2'h3) |=>
    ($stable(PUMP_GAIN) || !ACTIVE || PUMP_GAIN == 2'h3) [*8])
    else $error("gain changed during settling");
  sink_off_a: assert property ((!ACTIVE && !$past(ACTIVE)) |-> SINK_EN == {NUM_SINKS{1'b0}})
    else $error("sinks enabled outside active mode");
  bl_needs_active_a: assert property (BACKLIGHT_ON |-> $past(ACTIVE))
    else $error("backlight on outside active mode");
  softstart_gain_a: assert property ((SOFT_START_EN && $past(SOFT_START_EN)) |->
    PUMP_GAIN != 2'h1 && PUMP_GAIN != 2'h2)
    else $error("pumping gain during soft start");
endmodule // blgc_top_sva
`default_nettype wire

// file: testbench/blgc_host_model.sv
`timescale 1ns/10ps
`default_nettype none
// ---------------------------------------------------------------------------
// Host side of the register strobe bus.
// ---------------------------------------------------------------------------
module blgc_host_model (
  input  wire logic       clk,
  output var  logic       reg_wr,
  output var  logic       reg_rd,
  output var  logic [7:0] reg_addr,
  output var  logic [7:0] reg_wdata,
  input  wire logic [7:0] reg_rdata,
  input  wire logic       reg_ack
);
  // The bus is idle at time zero.
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
  end
  // One strobe, then a bounded wait for the acknowledge; address held meanwhile.
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] wd,
                      output logic [7:0] rd_d, output logic acked);
    reg_wr <= w;
    reg_rd <= !w;
    reg_addr <= a;
    reg_wdata <= wd;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    reg_wdata <= ~wd; // Released data does not keep its last value.
    acked = 1'b0;
    rd_d = 8'h00;
    for (int i = 0; i < 3 && !acked; i++) begin
      @(posedge clk);
      if (reg_ack === 1'b1) begin
        acked = 1'b1;
        rd_d = reg_rdata;
      end
    end
  endtask
  task automatic write(input logic [7:0] a, input logic [7:0] d, output logic acked);
    logic [7:0] x;
    xfer(1'b1, a, d, x, acked);
  endtask
  task automatic read(input logic [7:0] a, output logic [7:0] d, output logic acked);
    xfer(1'b0, a, 8'h00, d, acked);
  endtask
endmodule // blgc_host_model
`default_nettype wire

// file: testbench/test_backlight_mode_gain_control.sv
`timescale 1ns/10ps
`default_nettype none
module test_backlight_mode_gain_control;
  localparam int ST = 20;
  localparam int FL = 10;
  logic       clk = 1'b0, rst_b = 1'b0, pin_n = 1'b1, uvlo_n = 1'b1, fault = 1'b0;
  logic       ss_done = 1'b0, amb_v = 1'b0, wr, rd, ack, ss_en, active, bl_on, dim_sel, ok;
  logic [1:0] amb_lv = 2'h0, gain;
  logic [6:0] hr_low = 7'h00, hr_high = 7'h00, sink_en;
  logic [7:0] addr, wdata, rdata, max_lv, dim_lv, d;
  int         n_fail = 0, checked = 0;
  initial forever #2.5 clk = ~clk;
  blgc_top #(.NUM_SINKS(7), .SETTLE_CYC(ST), .FILTER_CYC(FL)) uut (.CORE_CLK(clk),
    .RST_B(rst_b), .HW_RESET_PIN_N(pin_n), .UVLO_N(uvlo_n), .FAULT(fault),
    .SOFT_START_DONE(ss_done), .HEADROOM_LOW(hr_low), .HEADROOM_HIGH(hr_high),
    .AMBIENT_LEVEL_VALID(amb_v), .AMBIENT_LEVEL(amb_lv), .REG_WR(wr), .REG_RD(rd),
    .REG_ADDR(addr), .REG_WDATA(wdata), .REG_RDATA(rdata), .REG_ACK(ack),
    .PUMP_GAIN(gain), .SOFT_START_EN(ss_en), .ACTIVE(active), .BACKLIGHT_ON(bl_on),
    .DIM_SEL(dim_sel), .MAX_LEVEL(max_lv), .DIM_LEVEL(dim_lv), .SINK_EN(sink_en));
  blgc_host_model host (.clk(clk), .reg_wr(wr), .reg_rd(rd), .reg_addr(addr),
    .reg_wdata(wdata), .reg_rdata(rdata), .reg_ack(ack));
  // ---------------------------------------------------------------------------
  // Shared helpers.
  // ---------------------------------------------------------------------------
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic summarize;
    $display("Comparisons %0d, mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // ---------------------------------------------------------------------------
  // Scenarios.
  // ---------------------------------------------------------------------------
  task automatic t_reset;
    host.read(8'h01, d, ok); check(d, 8'h00);
    host.read(8'h04, d, ok); check(d, 8'h00);
    host.read(8'h10, d, ok); check(d, 8'h7f);
    check({7'h00, active}, 8'h00);
  endtask
  task automatic t_level;
    for (int i = 0; i < 6; i++) host.write(8'(8'h09 + i), 8'(8'h11 * (i + 1)), ok);
    for (int l = 0; l < 3; l++) begin
      host.write(8'h04, 8'(l), ok);
      cyc(3);
      check(max_lv, 8'(8'h11 * (2 * l + 1)));
      check(dim_lv, 8'(8'h11 * (2 * l + 2)));
    end
    host.read(8'h0e, d, ok); check(d, 8'h66);
    host.write(8'h04, 8'h00, ok);
  endtask
  task automatic t_active;
    host.write(8'h01, 8'h23, ok); cyc(3);
    check({5'h00, dim_sel, active, ss_en}, 8'h07);
    ss_done <= 1'b1; cyc(8);
    host.read(8'h11, d, ok); check(d, 8'h04); check({6'h00, gain}, 8'h00);
    check({bl_on, sink_en}, 8'hff);
  endtask
  task automatic t_gain;
    hr_low <= 7'h01; cyc(6);
    check({6'h00, gain}, 8'h01);
    cyc(ST / 2); check({6'h00, gain}, 8'h01);
    cyc(ST); check({6'h00, gain}, 8'h02);
    hr_low <= 7'h00; hr_high <= 7'h7f; cyc(ST + 6);
    check({6'h00, gain}, 8'h01);
    cyc(ST + 6); check({6'h00, gain}, 8'h00);
    host.write(8'h10, 8'h7e, ok); hr_high <= 7'h00; hr_low <= 7'h01; cyc(2 * ST);
    check({6'h00, gain}, 8'h00);
    hr_low <= 7'h00; cyc(3); host.write(8'h10, 8'h7f, ok);
  endtask
  task automatic t_fault;
    ss_done <= 1'b0; fault <= 1'b1; cyc(8);
    check({6'h00, gain}, 8'h03);
    fault <= 1'b0; cyc(5);
    check({7'h00, ss_en}, 8'h01);
    ss_done <= 1'b1; cyc(8);
    check({6'h00, gain}, 8'h00);
  endtask
  task automatic t_standby;
    host.write(8'h01, 8'h01, ok); ss_done <= 1'b0; cyc(4);
    check({6'h00, active, bl_on}, 8'h00);
    host.write(8'h01, 8'h21, ok); cyc(3);
    check({7'h00, ss_en}, 8'h01);
    ss_done <= 1'b1; cyc(8);
  endtask
  task automatic t_pin;
    pin_n <= 1'b0; cyc(FL - 3); pin_n <= 1'b1; cyc(4);
    check({7'h00, active}, 8'h01);
    pin_n <= 1'b0; cyc(FL + 6);
    check({7'h00, active}, 8'h00);
    host.write(8'h04, 8'h02, ok); check({7'h00, ok}, 8'h00);
    pin_n <= 1'b1; cyc(4);
    host.read(8'h01, d, ok); check(d, 8'h00);
    check({7'h00, ok}, 8'h01);
    cyc(4); check({7'h00, active}, 8'h00);
  endtask
  task automatic t_uvlo;
    host.write(8'h04, 8'h01, ok);
    uvlo_n <= 1'b0; cyc(6);
    host.read(8'h04, d, ok); check({7'h00, ok}, 8'h00);
    uvlo_n <= 1'b1; cyc(4);
    host.read(8'h04, d, ok); check(d, 8'h00);
  endtask
  task automatic t_ambient;
    host.write(8'h01, 8'h10, ok);
    amb_lv <= 2'h2; amb_v <= 1'b1; cyc(1); amb_v <= 1'b0; cyc(2);
    host.write(8'h04, 8'h01, ok);
    host.read(8'h04, d, ok); check({6'h00, d[1:0]}, 8'h02);
    host.write(8'h01, 8'h00, ok); host.write(8'h04, 8'h01, ok);
    host.read(8'h04, d, ok); check({6'h00, d[1:0]}, 8'h01);
  endtask
  // Main sequence: reset held for 20 cycles, then each scenario in turn.
  initial begin
    cyc(20); rst_b <= 1'b1; cyc(2);
    t_reset; t_level; t_active; t_gain; t_fault; t_standby; t_pin; t_uvlo; t_ambient;
    summarize;
  end
  // Watchdog well beyond the expected run of about three hundred cycles.
  initial begin
    cyc(20000); n_fail++; summarize;
  end
endmodule // test_backlight_mode_gain_control
bind blgc_top blgc_top_sva #(.NUM_SINKS(NUM_SINKS), .FILTER_CYC(FILTER_CYC)) chk (
  .CORE_CLK(CORE_CLK), .RST_B(RST_B), .HW_RESET_PIN_N(HW_RESET_PIN_N), .UVLO_N(UVLO_N),
  .FAULT(FAULT), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_ACK(REG_ACK), .PUMP_GAIN(PUMP_GAIN),
  .SOFT_START_EN(SOFT_START_EN), .ACTIVE(ACTIVE), .BACKLIGHT_ON(BACKLIGHT_ON),
  .SINK_EN(SINK_EN));
`default_nettype wire
